/* File: sdft_pkg.sv */
// Shared constants and types of the sigma-delta filter timing block.
package sdft_pkg;
    //==========================================================
    // Clocks
    localparam int unsigned MCLK_KHZ = 4920;
    localparam int unsigned PCLK_KHZ = 50000;
    localparam int unsigned PHASE_W = 16;
    localparam logic [PHASE_W-1:0] PHASE_STEP = PHASE_W'(MCLK_KHZ);
    localparam logic [PHASE_W-1:0] PHASE_MOD = PHASE_W'(PCLK_KHZ);
    //==========================================================
    // Filter timing
    localparam int unsigned DECIM_DEF = 1024;
    localparam int unsigned FS_W = 10;
    localparam int unsigned FS_MAX = 1023;
    localparam int unsigned SINC3_ORDER = 3;
    localparam int unsigned SINC4_ORDER = 4;
    localparam int unsigned CHOP_SETTLE = 2;
    localparam int unsigned PLAIN_SETTLE = 1;
    localparam int unsigned CHAN_W = 4;
    //==========================================================
    // Register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CHAN = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_DATA = 8'h0c;
    localparam logic [7:0] ADDR_NOTCH = 8'h10;
    localparam int unsigned CTRL_FS_LSB = 0;
    localparam int unsigned CTRL_AVG_LO = 16;
    localparam int unsigned CTRL_AVG_HI = 17;
    localparam int unsigned CTRL_SIXTY = 20;
    localparam int unsigned CTRL_CHOP = 21;
    localparam int unsigned CTRL_RUN = 24;
    localparam logic [FS_W-1:0] FS_RST = 10'h060;
    localparam int unsigned STAT_RUN = 0;
    localparam int unsigned STAT_SETTLE = 1;
    localparam int unsigned STAT_CHOP = 2;
    localparam int unsigned STAT_READY = 3;
    localparam int unsigned STAT_CHAN_LSB = 4;
    //==========================================================
    // Conversion engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETTLE = 2'b01,
        ST_RUN = 2'b10
    } sdft_state_e;
endpackage : sdft_pkg

/* File: sdft_tick_if.sv */
// Link between the conversion engine and the sinc decimation counter.
`timescale 1ns/1ps
`default_nettype none
interface sdft_tick_if #(parameter int unsigned DIV_W = 20);
    logic ce;
    logic mclk_en;
    logic clear;
    logic [DIV_W-1:0] div;
    logic tick;
    modport ctrl (output ce, output mclk_en, output clear, output div, input tick);
    modport cnt (input ce, input mclk_en, input clear, input div, output tick);
endinterface : sdft_tick_if
`default_nettype wire

/* File: sdft_sinc_tick.sv */
// Sinc decimation counter: one tick per sinc output word.
`timescale 1ns/1ps
`default_nettype none
module sdft_sinc_tick
    import sdft_pkg::*;
#(
    parameter int unsigned DIV_W = 20
)(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Engine side
    sdft_tick_if.cnt tk
);
    logic [DIV_W-1:0] cnt_q, cnt_d;
    logic tick_q, tick_d;
    logic [DIV_W-1:0] seen_q, seen_d;

    //==========================================================
    // Counter
    always_comb begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (tk.clear) begin
            cnt_d = '0;
        end else if (tk.mclk_en) begin
            if (cnt_q >= tk.div - DIV_W'(1)) begin
                cnt_d = '0;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tk.ce) begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tk.tick = tick_q;

    //==========================================================
    // Checks
    always_comb begin
        seen_d = seen_q;
        if (tk.clear || tick_d) begin
            seen_d = '0;
        end else if (tk.mclk_en) begin
            seen_d = seen_q + DIV_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_q <= '0;
        end else if (tk.ce) begin
            seen_q <= seen_d;
        end
    end

    a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        (tk.ce && tick_d && !tk.clear) |-> (seen_q + DIV_W'(1) == tk.div))
        else $error("sinc tick spacing differs from the rate divisor");
endmodule : sdft_sinc_tick
`default_nettype wire

/* File: sdft_timing.sv */
// Conversion timing, decimation and postfilter control for the sigma-delta filter.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

//==============================================================
// Operation
// - Chopped sinc3: result every 3*1024*rate ticks
// - Chopping needs two periods to settle
// - Channel change resets modulator and filter
// - First result after settling, then periodic
// - Keep converting at rate after steps
// - Chop notches at odd half-rate multiples
// - Sixty hertz notch keeps the rate
// - Both average bits zero disable fast settling
// - Postfilter averages 2, 8 or 16 outputs
// - Fast sinc4: (3+average)*1024*rate ticks
// - Fast unchopped settles in one period
// - Asynchronous step gives one unsettled result
// - Chop in fast mode doubles settling only
// - First sinc notch at clock/(1024*rate)
// - Postfilter notches at sinc notch/average
// - Master clock nominally 4.92 MHz
// - Chopped sinc3 cutoff is 0.24 rate
// - Chop swaps polarity and averages pairs
module sdft_timing
    import sdft_pkg::*;
#(
    parameter int unsigned DECIM = DECIM_DEF,
    parameter int unsigned DATA_W = 24
)(
    // Clock, reset and freeze
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sinc stage
    input wire logic signed [DATA_W-1:0] sinc_data,
    output logic sinc_strobe,
    output logic sinc4_select,
    output logic sixty_notch_on,
    // Front end
    output logic filter_reset,
    output logic chop_swap,
    // Results
    output logic [DATA_W-1:0] result_data,
    output logic [CHAN_W-1:0] result_chan,
    output logic result_valid
);
    localparam int unsigned DIV_W = $clog2(DECIM * FS_MAX + 1);
    localparam int unsigned ACC_W = DATA_W + 4;

    if (DECIM < 1 || DECIM > DECIM_DEF || DATA_W < 8 || DATA_W > 31) begin : g_bad_param
        $error("sdft_timing: DECIM or DATA_W out of range");
    end

    function automatic logic [2:0] avg_shift(input logic [1:0] sel);
        case (sel)
            2'b01: avg_shift = 3'd1;
            2'b10: avg_shift = 3'd3;
            2'b11: avg_shift = 3'd4;
            default: avg_shift = 3'd0;
        endcase
    endfunction : avg_shift

    function automatic logic addr_known(input logic [7:0] a);
        if (a == ADDR_CTRL) addr_known = 1'b1;
        else if (a == ADDR_CHAN) addr_known = 1'b1;
        else if (a == ADDR_STAT) addr_known = 1'b1;
        else if (a == ADDR_DATA) addr_known = 1'b1;
        else if (a == ADDR_NOTCH) addr_known = 1'b1;
        else addr_known = 1'b0;
    endfunction : addr_known

    sdft_tick_if #(.DIV_W(DIV_W)) tk ();

    sdft_sinc_tick #(.DIV_W(DIV_W)) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tk(tk)
    );

    //==========================================================
    // Master clock enable
    logic [PHASE_W-1:0] phase_q, phase_d;
    logic mclk_q, mclk_d;

    // A fractional accumulator keeps the long-run master rate exact.
    always_comb begin
        phase_d = phase_q + PHASE_STEP;
        mclk_d = 1'b0;
        if (phase_d >= PHASE_MOD) begin
            phase_d = phase_d - PHASE_MOD;
            mclk_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= '0;
            mclk_q <= 1'b0;
        end else if (ce) begin
            phase_q <= phase_d;
            mclk_q <= mclk_d;
        end
    end

    //==========================================================
    // Mode decode
    logic fast, chop_on;
    logic [2:0] sh;
    logic [4:0] avg_n, mult;
    logic [1:0] need;
    logic [FS_W-1:0] fs_q, fs_d;
    logic [1:0] avg_q, avg_d;
    logic sixty_q, sixty_d, chop_q, chop_d, run_q, run_d;
    logic [CHAN_W-1:0] chan_q, chan_d;
    logic restart_q, restart_d;

    assign fast = |avg_q;
    assign chop_on = !fast || chop_q;
    assign sh = avg_shift(avg_q);
    assign avg_n = 5'd1 << sh;
    assign mult = fast ? 5'(SINC4_ORDER - 1) + avg_n : 5'(SINC3_ORDER);
    assign need = chop_on ? 2'(CHOP_SETTLE) : 2'(PLAIN_SETTLE);
    assign tk.ce = ce;
    assign tk.mclk_en = mclk_q;
    assign tk.clear = restart_q || !run_q;
    assign tk.div = DIV_W'(DECIM) * DIV_W'(fs_q);

    //==========================================================
    // Conversion engine
    sdft_state_e state_q, state_d;
    logic [4:0] k_q, k_d;
    logic signed [ACC_W-1:0] acc_q, acc_d, acc_sum;
    logic signed [DATA_W-1:0] prev_q, prev_d, conv;
    logic signed [DATA_W:0] diff;
    logic swap_q, swap_d, sinc4_q, sinc4_d;
    logic [1:0] settle_q, settle_d;
    logic [DATA_W-1:0] result_q, result_d;
    logic [CHAN_W-1:0] rchan_q, rchan_d;
    logic rvalid_q, rvalid_d, conv_end;

    assign conv_end = tk.tick && run_q && !restart_q && (k_q + 5'd1 == mult);

    always_comb begin
        state_d = state_q;
        k_d = k_q;
        acc_d = acc_q;
        prev_d = prev_q;
        swap_d = swap_q;
        settle_d = settle_q;
        result_d = result_q;
        rchan_d = rchan_q;
        rvalid_d = 1'b0;
        sinc4_d = fast;
        acc_sum = acc_q;
        conv = '0;
        diff = '0;
        if (restart_q || !run_q) begin
            state_d = run_q ? ST_SETTLE : ST_IDLE;
            k_d = '0;
            acc_d = '0;
            prev_d = '0;
            swap_d = 1'b0;
            settle_d = '0;
        end else if (tk.tick) begin
            // Input steps are not detected; the cadence never restarts on its own.
            if (k_q + 5'd1 > mult - avg_n) begin
                acc_sum = acc_q + ACC_W'(sinc_data);
            end
            k_d = k_q + 5'd1;
            acc_d = acc_sum;
            if (conv_end) begin
                k_d = '0;
                acc_d = '0;
                conv = DATA_W'(acc_sum >>> sh);
                prev_d = conv;
                swap_d = chop_on ? !swap_q : swap_q;
                if (swap_q) begin
                    diff = (DATA_W + 1)'(prev_q) - (DATA_W + 1)'(conv);
                end else begin
                    diff = (DATA_W + 1)'(conv) - (DATA_W + 1)'(prev_q);
                end
                if (settle_q < need) begin
                    settle_d = settle_q + 2'd1;
                end
                // Pair averaging of opposite polarities gives the half-rate notches.
                if (settle_q + 2'd1 >= need) begin
                    state_d = ST_RUN;
                    rvalid_d = 1'b1;
                    rchan_d = chan_q;
                    result_d = chop_on ? DATA_W'(diff >>> 1) : conv;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            k_q <= '0;
            acc_q <= '0;
            prev_q <= '0;
            swap_q <= 1'b0;
            settle_q <= '0;
            result_q <= '0;
            rchan_q <= '0;
            rvalid_q <= 1'b0;
            sinc4_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            k_q <= k_d;
            acc_q <= acc_d;
            prev_q <= prev_d;
            swap_q <= swap_d;
            settle_q <= settle_d;
            result_q <= result_d;
            rchan_q <= rchan_d;
            rvalid_q <= rvalid_d;
            sinc4_q <= sinc4_d;
        end
    end

    //==========================================================
    // APB registers
    logic setup, wr_en, rd_data;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d, ready_q, ready_d;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
    assign rd_data = psel && penable && pready_q && !pwrite && paddr == ADDR_DATA;

    always_comb begin
        fs_d = fs_q;
        avg_d = avg_q;
        sixty_d = sixty_q;
        chop_d = chop_q;
        run_d = run_q;
        chan_d = chan_q;
        restart_d = 1'b0;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        // A new result wins over a read that clears the flag.
        ready_d = (ready_q && !rd_data) || rvalid_d;
        if (setup) begin
            pready_d = 1'b1;
            pslverr_d = !addr_known(paddr);
            prdata_d = '0;
            if (paddr == ADDR_CTRL) begin
                prdata_d[CTRL_FS_LSB +: FS_W] = fs_q;
                prdata_d[CTRL_AVG_LO] = avg_q[0];
                prdata_d[CTRL_AVG_HI] = avg_q[1];
                prdata_d[CTRL_SIXTY] = sixty_q;
                prdata_d[CTRL_CHOP] = chop_q;
                prdata_d[CTRL_RUN] = run_q;
            end else if (paddr == ADDR_CHAN) begin
                prdata_d[CHAN_W-1:0] = chan_q;
            end else if (paddr == ADDR_STAT) begin
                prdata_d[STAT_RUN] = state_q == ST_RUN;
                prdata_d[STAT_SETTLE] = state_q == ST_SETTLE;
                prdata_d[STAT_CHOP] = swap_q;
                prdata_d[STAT_READY] = ready_q;
                prdata_d[STAT_CHAN_LSB +: CHAN_W] = rchan_q;
            end else if (paddr == ADDR_DATA) begin
                prdata_d[DATA_W-1:0] = result_q;
            end else if (paddr == ADDR_NOTCH) begin
                prdata_d[DIV_W-1:0] = tk.div;
            end
        end
        if (wr_en) begin
            if (paddr == ADDR_CTRL) begin
                fs_d = pwdata[CTRL_FS_LSB +: FS_W];
                if (fs_d == '0) begin
                    fs_d = FS_W'(1);
                end
                avg_d = {pwdata[CTRL_AVG_HI], pwdata[CTRL_AVG_LO]};
                sixty_d = pwdata[CTRL_SIXTY];
                chop_d = pwdata[CTRL_CHOP];
                run_d = pwdata[CTRL_RUN];
                restart_d = 1'b1;
            end else if (paddr == ADDR_CHAN) begin
                chan_d = pwdata[CHAN_W-1:0];
                restart_d = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_q <= FS_RST;
            avg_q <= 2'b00;
            sixty_q <= 1'b0;
            chop_q <= 1'b0;
            run_q <= 1'b0;
            chan_q <= '0;
            restart_q <= 1'b0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
            ready_q <= 1'b0;
        end else if (ce) begin
            fs_q <= fs_d;
            avg_q <= avg_d;
            sixty_q <= sixty_d;
            chop_q <= chop_d;
            run_q <= run_d;
            chan_q <= chan_d;
            restart_q <= restart_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            ready_q <= ready_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign sinc_strobe = tk.tick;
    assign sinc4_select = sinc4_q;
    assign sixty_notch_on = sixty_q;
    assign filter_reset = restart_q;
    assign chop_swap = swap_q;
    assign result_data = result_q;
    assign result_chan = rchan_q;
    assign result_valid = rvalid_q;

    //==========================================================
    // Checks
    logic [31:0] mc_q, mc_d;
    logic [1:0] seen_q, seen_d;

    always_comb begin
        mc_d = mc_q;
        seen_d = seen_q;
        if (tk.clear) begin
            mc_d = '0;
            seen_d = '0;
        end else if (conv_end) begin
            mc_d = {31'h0, mclk_q};
            seen_d = (seen_q == 2'd3) ? seen_q : seen_q + 2'd1;
        end else if (mclk_q) begin
            mc_d = mc_q + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mc_q <= '0;
            seen_q <= '0;
        end else if (ce) begin
            mc_q <= mc_d;
            seen_q <= seen_d;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_chan_write;
        ce && wr_en && paddr == ADDR_CHAN;
    endsequence

    sequence s_reset_pulse;
        filter_reset ##1 (state_q != ST_RUN);
    endsequence

    a_conv_period: assert property (conv_end |-> mc_q == 32'(mult) * 32'(tk.div))
        else $error("conversion period differs from order times divisor");
    a_fast_mult: assert property (avg_q == 2'b11 |-> mult == 5'd19)
        else $error("average by 16 does not give 19 sinc periods");
    a_chan_reset: assert property (s_chan_write |=> s_reset_pulse)
        else $error("channel write did not reset the filter");
    a_chop_settle: assert property (result_valid && chop_on |-> seen_q >= 2'd2)
        else $error("chopped result before two conversions");
    a_fast_settle: assert property (ce && conv_end && !chop_on |=> result_valid)
        else $error("unchopped fast conversion gave no result");
    a_chop_toggle: assert property (ce && conv_end && chop_on |=> chop_swap != $past(chop_swap))
        else $error("chop polarity did not swap at conversion end");
    a_sixty_write: assert property ($changed(sixty_notch_on) |-> filter_reset)
        else $error("notch bit changed outside a control write");
    a_rate_clamp: assert property (fs_q != '0)
        else $error("rate word holds zero");
    a_mode_sel: assert property (ce && avg_q == 2'b00 |=> !sinc4_select)
        else $error("fast settling active with average bits zero");
endmodule : sdft_timing
`default_nettype wire

/* File: tb_sdft_timing.sv */
// Self-checking testbench for the sigma-delta filter timing block.
`timescale 1ns/1ps
`default_nettype none
module tb_sdft_timing;
    import sdft_pkg::*;
    localparam int DECIM_TB = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sinc_strobe, sinc4_select, sixty_notch_on;
    logic filter_reset, chop_swap, result_valid;
    logic signed [23:0] sinc_data = 24'sh123456;
    logic [23:0] result_data;
    logic [CHAN_W-1:0] result_chan;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    int scnt = 0;
    int res_n = 0;
    int res_at[4];
    int res_t[4];
    logic res_cs[4];

    always #10 pclk = ~pclk;

    sdft_timing #(.DECIM(DECIM_TB), .DATA_W(24)) u_sdft_timing (
        .pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sinc_data(sinc_data), .sinc_strobe(sinc_strobe), .sinc4_select(sinc4_select),
        .sixty_notch_on(sixty_notch_on), .filter_reset(filter_reset),
        .chop_swap(chop_swap), .result_data(result_data), .result_chan(result_chan),
        .result_valid(result_valid)
    );

    //==========================================================
    // Monitor
    // Strobes are counted from each filter restart, so the first and next result checks do not
    // depend on the fractional master tick spacing; the period check allows 12 cycles either way.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (filter_reset === 1'b1) begin
            scnt <= 0;
            res_n <= 0;
        end else begin
            if (sinc_strobe === 1'b1) scnt <= scnt + 1;
            if (result_valid === 1'b1 && res_n < 4) begin
                res_at[res_n] <= scnt;
                res_t[res_n] <= cyc;
                res_cs[res_n] <= chop_swap;
                res_n <= res_n + 1;
            end
        end
    end

    always @(posedge pclk) begin
        if (cyc == 30000) begin
            error_cnt++;
            give_verdict();
        end
    end

    //==========================================================
    // Tasks
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(nm, r & m, exp);
    endtask : rd_chk

    // Lets the restart pulse clear the monitor before results are awaited.
    task automatic wait_res(input int n);
        repeat (3) @(posedge pclk);
        while (res_n < n) @(posedge pclk);
    endtask : wait_res

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    //==========================================================
    // Tests
    int c_avg[5] = '{0, 1, 2, 3, 1};
    int c_chop[5] = '{1, 0, 0, 1, 1};
    int c_first[5] = '{6, 5, 11, 38, 10};
    int c_per[5] = '{3, 5, 11, 19, 5};
    int c_rate[5] = '{2, 1, 1, 1, 1};
    logic [31:0] ctrl, expd;
    int dt, expt;
    logic [31:0] r;
    logic e;

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        check("reset valid", result_valid, 0);
        rd_chk("reset ctrl", ADDR_CTRL, 32'hffffffff, 32'h60);
        rd_chk("reset chan", ADDR_CHAN, 32'hffffffff, 32'h0);
        rd_chk("reset stat", ADDR_STAT, 32'hffffffff, 32'h0);
        rd_chk("notch 96", ADDR_NOTCH, 32'hffffffff, DECIM_TB * 96);
        wr(ADDR_CTRL, 32'h3ff);
        rd_chk("ctrl 1023", ADDR_CTRL, 32'h3ff, 32'h3ff);
        rd_chk("notch 1023", ADDR_NOTCH, 32'hffffffff, DECIM_TB * 1023);
        wr(ADDR_NOTCH, 32'h5);
        rd_chk("notch ro", ADDR_NOTCH, 32'hffffffff, DECIM_TB * 1023);
        apb(1'b0, 8'h14, 32'h0, r, e);
        check("unmapped err", e, 1);
        check("unmapped data", r, 0);
        $display("Test registers done");
        for (int i = 0; i < 5; i++) begin
            ctrl = c_rate[i] | (c_avg[i] << CTRL_AVG_LO) | (c_chop[i] << CTRL_CHOP);
            ctrl = ctrl | (32'(i == 2) << CTRL_SIXTY) | (32'h1 << CTRL_RUN);
            expd = (c_chop[i] != 0) ? 32'h0 : 32'h123456;
            wr(ADDR_CHAN, 32'(i + 3));
            wr(ADDR_CTRL, ctrl);
            wait_res(2);
            check("first result", res_at[0], c_first[i]);
            check("next result", res_at[1], c_first[i] + c_per[i]);
            dt = res_t[1] - res_t[0];
            expt = c_per[i] * DECIM_TB * c_rate[i] * 50000 / 4920;
            check("period cycles", dt >= expt - 12 && dt <= expt + 12, 1);
            check("result chan", result_chan, i + 3);
            check("result data", result_data, expd);
            check("fast select", sinc4_select, c_avg[i] != 0);
            check("sixty notch", sixty_notch_on, i == 2);
            if (c_chop[i] != 0) check("chop swap", res_cs[0] != res_cs[1], 1);
            rd_chk("stat ready", ADDR_STAT, 32'hf8, 32'h8 | ((i + 3) << STAT_CHAN_LSB));
            rd_chk("data reg", ADDR_DATA, 32'hffffff, expd);
            rd_chk("stat clear", ADDR_STAT, 32'h8, 32'h0);
            wr(ADDR_CHAN, 32'(i + 4));
            wait_res(1);
            check("chan change", res_at[0], c_first[i]);
            check("new chan", result_chan, i + 4);
            $display("Test mode %0d done", i);
        end
        ce <= 1'b0;
        repeat (2) @(posedge pclk);
        dt = scnt + res_n;
        repeat (300) @(posedge pclk);
        check("frozen count", scnt + res_n, dt);
        check("frozen strobe", sinc_strobe, 0);
        ce <= 1'b1;
        $display("Test freeze done");
        wr(ADDR_CTRL, 32'h1);
        repeat (400) @(posedge pclk);
        check("stopped", res_n, 0);
        $display("Test stop done");
        give_verdict();
    end
endmodule : tb_sdft_timing
`default_nettype wire
